//--- verilog/rrd_regs.svh
// Constants of the rotate-right datapath: opcode patterns, addressing
// limits and reset values.
// Assumes it is included by its bare name wherever the values are needed.
`ifndef RRD_REGS_SVH
`define RRD_REGS_SVH

// Upper six opcode bits of the two rotate instructions.
`define RRD_OPC_THROUGH_CARRY 6'h0c
`define RRD_OPC_WRAP          6'h10
// Field positions within the 16-bit instruction word.
`define RRD_OPC_MSB           15
`define RRD_OPC_LSB           10
`define RRD_DEST_BIT          9
`define RRD_ACCESS_BIT        8
// Highest file address that uses indexed literal offset addressing.
`define RRD_INDEXED_LIMIT     8'h5f
// Lowest access-bank address mapped to the top bank, plain mode.
`define RRD_ACCESS_SPLIT      8'h80
// Lowest access-bank address mapped to the top bank, extended mode.
`define RRD_ACCESS_SPLIT_EXT  8'h60
// Bank numbers that form the access bank.
`define RRD_ACCESS_LOW_BANK   4'h0
`define RRD_ACCESS_HIGH_BANK  4'hf
// Reset values of the status flags.
`define RRD_CARRY_RESET       1'b0
`define RRD_NEG_RESET         1'b0
`define RRD_ZERO_RESET        1'b0

`endif

//--- verilog/rrd_pkg.sv
// Types shared by the rotate-right datapath modules.
// Assumes the constants header is compiled alongside it.
`default_nettype none

package rrd_pkg;

   // Quarter phases of one instruction cycle, one-hot.
   typedef enum logic [3:0] {
      RRD_Q1 = 4'h1,
      RRD_Q2 = 4'h2,
      RRD_Q3 = 4'h4,
      RRD_Q4 = 4'h8
   } rrd_phase_e;

   // Operation held for the instruction in flight.
   typedef enum logic [1:0] {
      RRD_OP_NONE  = 2'h0,
      RRD_OP_CARRY = 2'h1,
      RRD_OP_WRAP  = 2'h2
   } rrd_op_e;

   // Complete state of the datapath.
   typedef struct packed {
      rrd_phase_e  phase;
      rrd_op_e     op;
      logic        toFile;
      logic [11:0] addr;
      logic [7:0]  operand;
      logic        memRdEn;
      logic [11:0] memAddr;
      logic        memWrEn;
      logic [7:0]  memWrData;
      logic        wWrEn;
      logic [7:0]  wWrData;
      logic        carry;
      logic        neg;
      logic        zero;
      logic        done;
   } rrd_state_s;

endpackage : rrd_pkg

`default_nettype wire

//--- verilog/rrd_rotator.sv
// Combinational rotate-right unit with flag results.
// Assumes the operand and carry come from registers on the same clock.
`default_nettype none
`timescale 1ns/10ps

module rrd_rotator (
   input  wire logic          throughCarry,
   input  wire logic [7:0]    operand,
   input  wire logic          carryIn,
   output logic      [7:0]    result,
   output logic               carryOut,
   output logic               negOut,
   output logic               zeroOut
);

   // Shift right one place; bit 7 gets the carry or the old bit 0.
   always_comb begin
      result   = {throughCarry ? carryIn : operand[0], operand[7:1]}; // [RQ1] [RQ3]
      carryOut = throughCarry ? operand[0] : carryIn; // [RQ1] [RQ3]
      negOut   = result[7]; // [RQ10]
      zeroOut  = (result == 8'h00); // [RQ10]
   end

endmodule : rrd_rotator

`default_nettype wire

//--- verilog/rrd_datapath.sv
// Execution datapath for the two rotate-right instructions of the core.
// Assumes instruction word, bank pointer, index base and read data come
// from core logic on the same clock; read data answers combinationally.
//
// How it works
// [RQ1] Through-carry rotate: bit0 to carry, carry to bit7.
// [RQ2] Opcode upper bits 0011 00da select through-carry.
// [RQ3] Wrap rotate: bit0 to bit7, carry kept.
// [RQ4] Opcode upper bits 0100 00da select wrap rotate.
// [RQ5] Destination bit 0 writes W, 1 writes file.
// [RQ6] Access bit 0 uses access bank, ignoring bank pointer.
// [RQ7] Extended set, access 0, f<=95: indexed literal offset.
// [RQ8] Access bit 1 selects general bank via pointer.
// [RQ9] One cycle: decode, read, process, write quarters.
// [RQ10] Negative is result bit 7; zero when result zero.
`default_nettype none
`timescale 1ns/10ps
`include "rrd_regs.svh"

module rrd_datapath (
   input  wire logic          clk,
   input  wire logic          rstn,
   input  wire logic          instrValid,
   input  wire logic [15:0]   instrWord,
   input  wire logic          extSetEnable,
   input  wire logic [3:0]    bankPointer,
   input  wire logic [11:0]   indexBase,
   input  wire logic [7:0]    memRdData,
   output logic      [3:0]    quarter,
   output logic               memRdEn,
   output logic      [11:0]   memAddr,
   output logic               memWrEn,
   output logic      [7:0]    memWrData,
   output logic               wWrEn,
   output logic      [7:0]    wWrData,
   output logic               carryFlag,
   output logic               negFlag,
   output logic               zeroFlag,
   output logic               instrDone
);

   // ****************************************************************
   // State and rotate unit
   // ****************************************************************

   rrd_pkg::rrd_state_s state_q;
   rrd_pkg::rrd_state_s state_d;

   logic [7:0]  rotResult;
   logic        rotCarry;
   logic        rotNeg;
   logic        rotZero;
   logic [5:0]  opcode;
   logic [7:0]  fileAddr;
   logic        accessBit;
   logic [11:0] effAddr;
   logic [7:0]  accessSplit;

   // Rotation and flag results from the captured operand.
   rrd_rotator u_rotator (
      .throughCarry (state_q.op == rrd_pkg::RRD_OP_CARRY),
      .operand      (state_q.operand),
      .carryIn      (state_q.carry),
      .result       (rotResult),
      .carryOut     (rotCarry),
      .negOut       (rotNeg),
      .zeroOut      (rotZero)
   );

   // ****************************************************************
   // Operand addressing
   // ****************************************************************

   // Instruction fields used by decode and address selection.
   assign opcode    = instrWord[`RRD_OPC_MSB:`RRD_OPC_LSB];
   assign fileAddr  = instrWord[7:0];
   assign accessBit = instrWord[`RRD_ACCESS_BIT];

   // The access bank splits lower in extended mode, since its low part
   // is taken by the indexed window.
   assign accessSplit = extSetEnable ? `RRD_ACCESS_SPLIT_EXT
                                     : `RRD_ACCESS_SPLIT;

   // Full data address of the operand.
   always_comb begin
      if (accessBit) begin
         effAddr = {bankPointer, fileAddr}; // [RQ6] [RQ8]
      end else if (extSetEnable && (fileAddr <= `RRD_INDEXED_LIMIT)) begin
         effAddr = indexBase + {4'h0, fileAddr}; // [RQ7]
      end else if (fileAddr < accessSplit) begin
         effAddr = {`RRD_ACCESS_LOW_BANK, fileAddr}; // [RQ6]
      end else begin
         effAddr = {`RRD_ACCESS_HIGH_BANK, fileAddr}; // [RQ6]
      end
   end

   // ****************************************************************
   // Quarter sequencer and datapath
   // ****************************************************************

   // Next state: the quarters run free, and each does its own step.
   always_comb begin
      state_d         = state_q;
      state_d.memRdEn = 1'b0;
      state_d.memWrEn = 1'b0;
      state_d.wWrEn   = 1'b0;
      state_d.done    = 1'b0;
      unique case (state_q.phase)
         rrd_pkg::RRD_Q1: begin
            // Decode; the read is presented during the second quarter.
            state_d.phase  = rrd_pkg::RRD_Q2; // [RQ9]
            state_d.op     = rrd_pkg::RRD_OP_NONE;
            state_d.toFile = instrWord[`RRD_DEST_BIT];
            state_d.addr   = effAddr;
            if (instrValid && (opcode == `RRD_OPC_THROUGH_CARRY)) begin
               state_d.op = rrd_pkg::RRD_OP_CARRY; // [RQ2]
            end else if (instrValid && (opcode == `RRD_OPC_WRAP)) begin
               state_d.op = rrd_pkg::RRD_OP_WRAP; // [RQ4]
            end
            if (instrValid && ((opcode == `RRD_OPC_THROUGH_CARRY) ||
                               (opcode == `RRD_OPC_WRAP))) begin
               state_d.memRdEn = 1'b1; // [RQ9]
               state_d.memAddr = effAddr;
            end
         end
         rrd_pkg::RRD_Q2: begin
            // Capture the operand at the end of the read quarter.
            state_d.phase   = rrd_pkg::RRD_Q3; // [RQ9]
            state_d.operand = memRdData;
         end
         rrd_pkg::RRD_Q3: begin
            // Process; destination write and flags show in the fourth.
            state_d.phase = rrd_pkg::RRD_Q4; // [RQ9]
            if (state_q.op != rrd_pkg::RRD_OP_NONE) begin
               state_d.done  = 1'b1;
               state_d.carry = rotCarry; // [RQ1] [RQ3]
               state_d.neg   = rotNeg; // [RQ10]
               state_d.zero  = rotZero; // [RQ10]
               if (state_q.toFile) begin
                  state_d.memWrEn   = 1'b1; // [RQ5]
                  state_d.memAddr   = state_q.addr;
                  state_d.memWrData = rotResult;
               end else begin
                  state_d.wWrEn   = 1'b1; // [RQ5]
                  state_d.wWrData = rotResult;
               end
            end
         end
         rrd_pkg::RRD_Q4: begin
            state_d.phase = rrd_pkg::RRD_Q1; // [RQ9]
            state_d.op    = rrd_pkg::RRD_OP_NONE;
         end
         default: begin
            // An illegal phase code restarts the sequence.
            state_d.phase = rrd_pkg::RRD_Q1;
            state_d.op    = rrd_pkg::RRD_OP_NONE;
         end
      endcase
   end

   // Register the whole state; reset starts in the decode quarter.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q.phase     <= rrd_pkg::RRD_Q1;
         state_q.op        <= rrd_pkg::RRD_OP_NONE;
         state_q.toFile    <= 1'b0;
         state_q.addr      <= 12'h000;
         state_q.operand   <= 8'h00;
         state_q.memRdEn   <= 1'b0;
         state_q.memAddr   <= 12'h000;
         state_q.memWrEn   <= 1'b0;
         state_q.memWrData <= 8'h00;
         state_q.wWrEn     <= 1'b0;
         state_q.wWrData   <= 8'h00;
         state_q.carry     <= `RRD_CARRY_RESET;
         state_q.neg       <= `RRD_NEG_RESET;
         state_q.zero      <= `RRD_ZERO_RESET;
         state_q.done      <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Every output is a field of the registered state.
   assign quarter   = state_q.phase;
   assign memRdEn   = state_q.memRdEn;
   assign memAddr   = state_q.memAddr;
   assign memWrEn   = state_q.memWrEn;
   assign memWrData = state_q.memWrData;
   assign wWrEn     = state_q.wWrEn;
   assign wWrData   = state_q.wWrData;
   assign carryFlag = state_q.carry;
   assign negFlag   = state_q.neg;
   assign zeroFlag  = state_q.zero;
   assign instrDone = state_q.done;

endmodule : rrd_datapath

`default_nettype wire

//--- tb/rrd_datapath_sva.sv
// Checker of quarter timing, strobes and flags of the rotate datapath.
// Assumes it is bound to rrd_datapath with the constants header in reach.
`default_nettype none
`timescale 1ns/10ps
`include "rrd_regs.svh"

module rrd_datapath_sva (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        instrValid,
   input wire logic [15:0] instrWord,
   input wire logic [3:0]  quarter,
   input wire logic        memRdEn,
   input wire logic        memWrEn,
   input wire logic [7:0]  memWrData,
   input wire logic        wWrEn,
   input wire logic [7:0]  wWrData,
   input wire logic        carryFlag,
   input wire logic        negFlag,
   input wire logic        zeroFlag,
   input wire logic        instrDone
);
   // ************************************************************
   // Assertions on the ports
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // A rotate word is accepted only at the edge that ends the first quarter.
   wire logic take = (quarter == 4'h1) && instrValid &&
      (instrWord[15:10] == `RRD_OPC_THROUGH_CARRY ||
       instrWord[15:10] == `RRD_OPC_WRAP);
   phase_ring_a: assert property (quarter == 4'h1 |=> quarter == 4'h2 ##1
      quarter == 4'h4 ##1 quarter == 4'h8 ##1 quarter == 4'h1)
      else $error("quarter sequence broken");
   read_strobe_a: assert property (take |=> memRdEn ##1 !memRdEn)
      else $error("read strobe not in second quarter");
   done_time_a: assert property (take |-> ##3 instrDone ##1 !instrDone)
      else $error("done not in fourth quarter");
   w_dest_a: assert property (take && !instrWord[9] |-> ##3 wWrEn && !memWrEn)
      else $error("result not steered to W");
   file_dest_a: assert property (take && instrWord[9] |-> ##3 memWrEn && !wWrEn)
      else $error("result not steered to file");
   flag_value_a: assert property (instrDone |->
      negFlag == (wWrEn ? wWrData[7] : memWrData[7]) &&
      zeroFlag == ((wWrEn ? wWrData : memWrData) == 8'h00))
      else $error("negative or zero flag wrong");
   wrap_carry_a: assert property (take &&
      instrWord[15:10] == `RRD_OPC_WRAP |-> ##3 $stable(carryFlag))
      else $error("wrap rotate changed carry");
   refuse_op_a: assert property (quarter == 4'h1 && !take |-> ##3 !instrDone)
      else $error("foreign word executed");
   flag_hold_a: assert property (!instrDone |-> $stable(carryFlag) &&
      $stable(negFlag) && $stable(zeroFlag))
      else $error("flags moved outside fourth quarter");
endmodule : rrd_datapath_sva

bind rrd_datapath rrd_datapath_sva rrd_datapath_sva_i (
   .clk(clk), .rstn(rstn), .instrValid(instrValid), .instrWord(instrWord),
   .quarter(quarter), .memRdEn(memRdEn), .memWrEn(memWrEn),
   .memWrData(memWrData), .wWrEn(wWrEn), .wWrData(wWrData),
   .carryFlag(carryFlag), .negFlag(negFlag), .zeroFlag(zeroFlag),
   .instrDone(instrDone)
);

`default_nettype wire

//--- tb/rrd_datapath_tb.sv
// Self-checking bench of the rotate datapath.
// Assumes the design, package and header compile before it.
`default_nettype none
`timescale 1ns/10ps

module rrd_datapath_tb;
   logic        clk, rstn, instrValid, extSetEnable, c;
   logic [15:0] instrWord;
   logic [3:0]  bankPointer, quarter;
   logic [11:0] indexBase, memAddr;
   logic [7:0]  memRdData, memWrData, wWrData;
   logic        memRdEn, memWrEn, wWrEn, carryFlag, negFlag, zeroFlag;
   logic        instrDone;
   int          failures, compares, cyc;

   rrd_datapath rrd_datapath_i (
      .clk(clk), .rstn(rstn), .instrValid(instrValid),
      .instrWord(instrWord), .extSetEnable(extSetEnable),
      .bankPointer(bankPointer), .indexBase(indexBase),
      .memRdData(memRdData), .quarter(quarter), .memRdEn(memRdEn),
      .memAddr(memAddr), .memWrEn(memWrEn), .memWrData(memWrData),
      .wWrEn(wWrEn), .wWrData(wWrData), .carryFlag(carryFlag),
      .negFlag(negFlag), .zeroFlag(zeroFlag), .instrDone(instrDone)
   );

   // ************************************************************
   // Shared tasks
   // ************************************************************
   // Counts a comparison and reports a mismatch.
   task automatic chk(input string n, input logic [11:0] e, g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Runs one instruction through its four quarters and judges it.
   task automatic exe(input logic [15:0] w, input logic x,
      input logic [3:0] bp, input logic [11:0] ib,
      input logic [7:0] rd, input logic [11:0] ea);
      logic       cop;
      logic [7:0] res;
      cop = (w[15:10] == 6'h0c);
      res = cop ? {c, rd[7:1]} : {rd[0], rd[7:1]};
      while (quarter !== 4'h8) @(negedge clk);
      @(posedge clk);
      instrValid <= 1'h1;
      instrWord <= w;
      extSetEnable <= x;
      bankPointer <= bp;
      indexBase <= ib;
      @(posedge clk);
      instrValid <= 1'h0;
      memRdData <= rd;
      @(negedge clk);
      chk("rdEn", 1'h1, memRdEn);
      chk("addr", ea, memAddr);
      @(posedge clk);
      memRdData <= ~rd;
      @(negedge clk);
      @(negedge clk);
      if (cop) c = rd[0];
      chk("done", 1'h1, instrDone);
      chk("dest", {w[9], ~w[9]}, {memWrEn, wWrEn});
      chk("data", res, w[9] ? memWrData : wWrData);
      chk("carry", c, carryFlag);
      chk("nz", {res[7], res == 8'h00}, {negFlag, zeroFlag});
   endtask : exe

   // Offers a word that must be ignored and checks nothing happens.
   task automatic ign(input logic [15:0] w, input logic v);
      while (quarter !== 4'h8) @(negedge clk);
      @(posedge clk);
      instrValid <= v;
      instrWord <= w;
      @(posedge clk);
      instrValid <= 1'h0;
      @(negedge clk);
      chk("rdEnOff", 1'h0, memRdEn);
      @(negedge clk);
      @(negedge clk);
      chk("doneOff", 1'h0, instrDone);
      chk("wrOff", 2'h0, {memWrEn, wWrEn});
      chk("carryKept", c, carryFlag);
   endtask : ign

   // Through-carry rotates back to back, to W and to file.
   task automatic t_carry();
      exe(16'h3140, 1'h0, 4'h3, 12'h000, 8'he6, 12'h340);
      exe(16'h33ff, 1'h0, 4'hf, 12'h000, 8'h01, 12'hfff);
      exe(16'h3312, 1'h0, 4'ha, 12'h000, 8'h00, 12'ha12);
      $display("carry test done");
   endtask : t_carry

   // Wrap rotates with carry set beforehand; carry must stay.
   task automatic t_wrap();
      exe(16'h3100, 1'h0, 4'h1, 12'h000, 8'h01, 12'h100);
      exe(16'h437e, 1'h0, 4'h0, 12'h000, 8'hd7, 12'h07e);
      exe(16'h4101, 1'h0, 4'h2, 12'h000, 8'h02, 12'h201);
      $display("wrap test done");
   endtask : t_wrap

   // Access bank and indexed addressing, both modes and both limits.
   task automatic t_access();
      exe(16'h3020, 1'h1, 4'h5, 12'h120, 8'h81, 12'h140);
      exe(16'h405f, 1'h1, 4'h5, 12'hff0, 8'h3c, 12'h04f);
      exe(16'h3060, 1'h1, 4'h5, 12'h120, 8'h7e, 12'hf60);
      exe(16'h4270, 1'h0, 4'h5, 12'h120, 8'h55, 12'h070);
      exe(16'h3090, 1'h0, 4'h5, 12'h120, 8'hfe, 12'hf90);
      $display("access test done");
   endtask : t_access

   // Foreign opcodes and an unflagged rotate word are ignored.
   task automatic t_refuse();
      ign(16'h3400, 1'h1);
      ign(16'h4400, 1'h1);
      ign(16'h3000, 1'h0);
      $display("refuse test done");
   endtask : t_refuse

   // Reset in mid-run restarts the quarters and clears the flags.
   task automatic t_reset();
      @(posedge clk);
      rstn <= 1'h0;
      @(negedge clk);
      chk("rstQ", 4'h1, quarter);
      chk("rstFlags", 3'h0, {carryFlag, negFlag, zeroFlag});
      chk("rstDone", 1'h0, instrDone);
      c = 1'b0;
      @(posedge clk);
      rstn <= 1'h1;
      @(negedge clk);
      chk("relQ1", 4'h1, quarter);
      @(negedge clk);
      chk("relQ2", 4'h2, quarter);
      exe(16'h3001, 1'h0, 4'h0, 12'h000, 8'h80, 12'h001);
      $display("reset test done");
   endtask : t_reset

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run

   // Free-running 100 ns clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Cycle ceiling; running out counts as a mismatch.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         complete_run();
      end
   end

   // Reset for six cycles, then every scenario in turn.
   initial begin
      rstn = 1'b0;
      instrValid = 1'b0;
      instrWord = 16'h0000;
      extSetEnable = 1'b0;
      bankPointer = 4'h0;
      indexBase = 12'h000;
      memRdData = 8'h00;
      c = 1'b0;
      failures = 0;
      compares = 0;
      cyc = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_carry();
      t_wrap();
      t_access();
      t_refuse();
      t_reset();
      complete_run();
   end
endmodule : rrd_datapath_tb

//--- tb/rrd_datapath_tb_tail.sv
`default_nettype wire
